// [common/alsr_pkg.sv]
// Purpose: Shared constants and types for the application-layer state registers
// Assumes: 200 MHz mclk, byte-wide register accesses from both sides
// Notes:   Offsets are byte addresses in the controller register space
package alsr_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Address map
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFS_REQ_LO   = 12'h0120;
    localparam logic [11:0] OFS_REQ_HI   = 12'h0121;
    localparam logic [11:0] OFS_STAT_LO  = 12'h0130;
    localparam logic [11:0] OFS_STAT_HI  = 12'h0131;
    localparam logic [11:0] OFS_CODE_LO  = 12'h0134;
    localparam logic [11:0] OFS_CODE_HI  = 12'h0135;
    localparam logic [11:0] OFS_RUN_OVR  = 12'h0138;
    localparam logic [11:0] OFS_ERR_OVR  = 12'h0139;
    localparam logic [11:0] OFS_IF_SEL   = 12'h0140;

    ////////////////////////////////////////////////////////////////////////////
    // Field layout
    localparam int STATE_W      = 4;
    localparam int REQ_ACK_BIT  = 4;
    localparam int REQ_ID_BIT   = 5;
    localparam int STAT_ERR_BIT = 4;
    localparam int STAT_ID_BIT  = 5;
    localparam int LAMP_EN_BIT  = 4;

    localparam logic [3:0] ST_INIT   = 4'h1;
    localparam logic [3:0] ST_PRE_OPERATIONAL_STATE  = 4'h2;
    localparam logic [3:0] ST_BOOT   = 4'h3;
    localparam logic [3:0] ST_SAFE_OPERATIONAL_STATE = 4'h4;
    localparam logic [3:0] ST_OP     = 4'h8;

    localparam logic [3:0] LAMP_OFF     = 4'h0;
    localparam logic [3:0] LAMP_FLASH1  = 4'h1;
    localparam logic [3:0] LAMP_BLINK   = 4'hD;
    localparam logic [3:0] LAMP_FLICKER = 4'hE;
    localparam logic [3:0] LAMP_ON      = 4'hF;

    localparam logic [7:0]  IF_SEL_RESET = 8'h00;
    localparam logic [15:0] CODE_RESET   = 16'h0000;
    localparam logic [3:0]  STATE_RESET  = 4'h1;

    ////////////////////////////////////////////////////////////////////////////
    // Lamp timing; pattern lengths below are in units of one lamp tick
    localparam int CLK_PERIOD_NS    = 5;
    localparam int LAMP_TICK_MS     = 50;
    localparam int LAMP_TICK_CYCLES = LAMP_TICK_MS * 1000000 / CLK_PERIOD_NS;
    localparam int BLINK_HALF       = 4;
    localparam int FLICKER_HALF     = 1;
    localparam int FLASH_ON         = 4;
    localparam int FLASH_SLOT       = 8;
    localparam int FLASH_PAUSE      = 20;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [11:0]       addr;
        logic [7:0]        wdata;
    } alsr_bus_s;

    typedef enum {LOCK_OPEN, LOCK_HELD} alsr_lock_e;

    function automatic logic isValidState(input logic [3:0] st);
        return (st == ST_INIT) || (st == ST_PRE_OPERATIONAL_STATE) || (st == ST_BOOT)
            || (st == ST_SAFE_OPERATIONAL_STATE) || (st == ST_OP);
    endfunction

endpackage

// [rtl/alsr_lamp_gen.sv]
// Purpose: Turns a 4-bit lamp code into an on/off lamp drive
// Assumes: tick is a one-cycle enable once per lamp time unit
// Notes:   Pattern restarts whenever the code changes
`timescale 1ns/100ps
module alsr_lamp_gen
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rstn,
    // Pattern control
    input  wire logic        tick,
    input  wire logic [3:0]  code,
    // Lamp drive
    output logic             lampOut
);

    logic [7:0] phase_q;
    logic [3:0] codePrev_q;
    logic [7:0] flashLen;
    logic [7:0] period;
    logic       lamp_d;

    always_comb
    begin
        flashLen = 8'(code) * 8'(alsr_pkg::FLASH_SLOT);
        case (code)
            alsr_pkg::LAMP_BLINK:   period = 8'(2 * alsr_pkg::BLINK_HALF);
            alsr_pkg::LAMP_FLICKER: period = 8'(2 * alsr_pkg::FLICKER_HALF);
            alsr_pkg::LAMP_OFF:     period = 8'h01;
            alsr_pkg::LAMP_ON:      period = 8'h01;
            default:                period = flashLen + 8'(alsr_pkg::FLASH_PAUSE);
        endcase
    end

    // Phase restarts on a new code so a flash count always begins cleanly
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            phase_q    <= 8'h00;
            codePrev_q <= 4'h0;
        end
        else
        begin
            codePrev_q <= code;
            if (code != codePrev_q)
                phase_q <= 8'h00;
            else if (tick)
                phase_q <= (phase_q + 8'h01 >= period) ? 8'h00 : phase_q + 8'h01;
        end
    end

    always_comb
    begin
        case (code)
            alsr_pkg::LAMP_OFF:     lamp_d = 1'b0;
            alsr_pkg::LAMP_ON:      lamp_d = 1'b1;
            alsr_pkg::LAMP_BLINK:   lamp_d = phase_q < 8'(alsr_pkg::BLINK_HALF);
            alsr_pkg::LAMP_FLICKER: lamp_d = phase_q < 8'(alsr_pkg::FLICKER_HALF);
            default:
                lamp_d = (phase_q < flashLen)
                      && (8'(phase_q % 8'(alsr_pkg::FLASH_SLOT)) < 8'(alsr_pkg::FLASH_ON));
        endcase
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            lampOut <= 1'b0;
        else
            lampOut <= lamp_d;
    end

endmodule

// [rtl/alsr_regs.sv]
// Purpose: Application-layer state, reason code, lamp override and interface select registers
// Assumes: Network and host accesses are single-cycle byte strobes on mclk
// Notes:   Read data appear one cycle after the read strobe; unmapped reads return zero
`timescale 1ns/100ps
// Operation
// - Request codes 1,2,3,4,8 name the states
// - Network request bit 4 acknowledges error
// - Request bit 5 asks for identification
// - Network write locks until host acknowledges
// - Request register writable right after reset
// - Either request byte releases the lock
// - Emulation accepts every write, copies to actual
// - Read-acknowledge: host read clears host event
// - Write-acknowledge: host write clears, data ignored
// - Actual state encoding, network read-only
// - Error flag for failed or local change
// - Actual bit 5 shows identification loaded
// - Host writes actual only without emulation
// - Network read of actual clears network event
// - Reason code: network reads, host writes
// - Lamp codes off, flash, blink, flicker, on
// - Override bit selects override lamp code
// - Valid state change drops run override
// - New error drops fault override
// - Interface select read-only, loaded from config
// - Emulation bit selects who sets actual
// - Configuration bit selects acknowledge by write
module alsr_regs
#(
    parameter int unsigned TICK_CYCLES = alsr_pkg::LAMP_TICK_CYCLES
)
(
    // Clock and reset
    input  wire logic                mclk,
    input  wire logic                resetn,
    // Network side register access
    input  wire alsr_pkg::alsr_bus_s netReq,
    output logic [7:0]               netRdata,
    // Host side register access
    input  wire alsr_pkg::alsr_bus_s hostReq,
    output logic [7:0]               hostRdata,
    // Configuration from neighbouring registers
    input  wire logic                emulationOn,
    input  wire logic                writeAckOn,
    input  wire logic                ifSelLoad,
    input  wire logic [7:0]          ifSelData,
    // Device events
    input  wire logic                errorEvent,
    // Event request side effects
    output logic                     alReqEvent,
    output logic                     hostEvtClr,
    output logic                     netEvtClr,
    // Lamps
    output logic                     runLamp,
    output logic                     errLamp
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset release
    logic [1:0] rstPipe_q;
    logic       rstn;

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            rstPipe_q <= 2'b00;
        else
            rstPipe_q <= {rstPipe_q[0], 1'b1};
    end
    assign rstn = rstPipe_q[1];

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    alsr_pkg::alsr_lock_e lock_q;
    logic [5:0]  req_q;
    logic [3:0]  state_q;
    logic [3:0]  state_d;
    logic        errInd_q;
    logic        errInd_d;
    logic        idLoaded_q;
    logic        idLoaded_d;
    logic [15:0] reasonCode_q;
    logic        runEn_q;
    logic [3:0]  runCode_q;
    logic        errEn_q;
    logic [3:0]  errCode_q;
    logic [7:0]  ifSel_q;

    ////////////////////////////////////////////////////////////////////////////
    // Decode
    logic netReqHit;
    logic netAccept;
    logic hostReqHit;
    logic hostRelease;
    logic hostStatWr;
    logic stateChange;
    logic newError;
    logic [3:0] runEff;
    logic [3:0] errEff;
    logic [3:0] runNormal;

    assign netReqHit  = netReq.wr
                     && (netReq.addr == alsr_pkg::OFS_REQ_LO || netReq.addr == alsr_pkg::OFS_REQ_HI);
    assign hostReqHit = hostReq.addr == alsr_pkg::OFS_REQ_LO
                     || hostReq.addr == alsr_pkg::OFS_REQ_HI;
    // Acknowledge kind follows the write-acknowledge configuration bit
    assign hostRelease = hostReqHit
                      && (writeAckOn ? hostReq.wr : hostReq.rd);
    // Emulation bypasses the mailbox lock entirely
    assign netAccept  = netReqHit
                     && (emulationOn || lock_q == alsr_pkg::LOCK_OPEN);
    assign hostStatWr = hostReq.wr && !emulationOn
                     && hostReq.addr == alsr_pkg::OFS_STAT_LO;

    ////////////////////////////////////////////////////////////////////////////
    // Mailbox lock on the request register
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            lock_q <= alsr_pkg::LOCK_OPEN;
        else
        begin
            case (lock_q)
                alsr_pkg::LOCK_OPEN:
                    if (netAccept && !emulationOn)
                        lock_q <= alsr_pkg::LOCK_HELD;
                alsr_pkg::LOCK_HELD:
                    if (emulationOn || hostRelease)
                        lock_q <= alsr_pkg::LOCK_OPEN;
                default:
                    lock_q <= alsr_pkg::LOCK_OPEN;
            endcase
        end
    end

    // Host writes never alter the stored request
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            req_q <= 6'h00;
        else if (netAccept && netReq.addr == alsr_pkg::OFS_REQ_LO)
            req_q <= netReq.wdata[5:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Actual state
    always_comb
    begin
        state_d    = state_q;
        errInd_d   = errInd_q;
        idLoaded_d = idLoaded_q;
        if (emulationOn && netAccept && netReq.addr == alsr_pkg::OFS_REQ_LO)
        begin
            state_d    = netReq.wdata[3:0];
            idLoaded_d = netReq.wdata[alsr_pkg::REQ_ID_BIT];
            errInd_d   = 1'b0;
        end
        else if (hostStatWr)
        begin
            state_d    = hostReq.wdata[3:0];
            errInd_d   = hostReq.wdata[alsr_pkg::STAT_ERR_BIT];
            idLoaded_d = hostReq.wdata[alsr_pkg::STAT_ID_BIT];
        end
        if (netAccept && netReq.addr == alsr_pkg::OFS_REQ_LO
            && netReq.wdata[alsr_pkg::REQ_ACK_BIT])
            errInd_d = 1'b0;
        // A fresh error outranks an acknowledge in the same cycle
        if (errorEvent)
            errInd_d = 1'b1;
    end

    assign stateChange = state_d != state_q && alsr_pkg::isValidState(state_d);
    assign newError    = errInd_d && !errInd_q;

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q    <= alsr_pkg::STATE_RESET;
            errInd_q   <= 1'b0;
            idLoaded_q <= 1'b0;
        end
        else
        begin
            state_q    <= state_d;
            errInd_q   <= errInd_d;
            idLoaded_q <= idLoaded_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reason code, host writable only
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            reasonCode_q <= alsr_pkg::CODE_RESET;
        else if (hostReq.wr && hostReq.addr == alsr_pkg::OFS_CODE_LO)
            reasonCode_q[7:0] <= hostReq.wdata;
        else if (hostReq.wr && hostReq.addr == alsr_pkg::OFS_CODE_HI)
            reasonCode_q[15:8] <= hostReq.wdata;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Lamp overrides; network write wins a same-cycle collision, hardware clear wins over both
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            runEn_q   <= 1'b0;
            runCode_q <= alsr_pkg::LAMP_OFF;
        end
        else
        begin
            if (netReq.wr && netReq.addr == alsr_pkg::OFS_RUN_OVR)
                {runEn_q, runCode_q} <= netReq.wdata[4:0];
            else if (hostReq.wr && hostReq.addr == alsr_pkg::OFS_RUN_OVR)
                {runEn_q, runCode_q} <= hostReq.wdata[4:0];
            if (stateChange)
                runEn_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            errEn_q   <= 1'b0;
            errCode_q <= alsr_pkg::LAMP_OFF;
        end
        else
        begin
            if (netReq.wr && netReq.addr == alsr_pkg::OFS_ERR_OVR)
                {errEn_q, errCode_q} <= netReq.wdata[4:0];
            else if (hostReq.wr && hostReq.addr == alsr_pkg::OFS_ERR_OVR)
                {errEn_q, errCode_q} <= hostReq.wdata[4:0];
            if (newError)
                errEn_q <= 1'b0;
        end
    end

    always_comb
    begin
        case (state_q)
            alsr_pkg::ST_PRE_OPERATIONAL_STATE:  runNormal = alsr_pkg::LAMP_BLINK;
            alsr_pkg::ST_BOOT:   runNormal = alsr_pkg::LAMP_FLICKER;
            alsr_pkg::ST_SAFE_OPERATIONAL_STATE: runNormal = alsr_pkg::LAMP_FLASH1;
            alsr_pkg::ST_OP:     runNormal = alsr_pkg::LAMP_ON;
            default:             runNormal = alsr_pkg::LAMP_OFF;
        endcase
    end

    assign runEff = runEn_q ? runCode_q : runNormal;
    assign errEff = errEn_q ? errCode_q
                  : (errInd_q ? alsr_pkg::LAMP_BLINK : alsr_pkg::LAMP_OFF);

    ////////////////////////////////////////////////////////////////////////////
    // Interface select, loaded by the configuration loader only
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            ifSel_q <= alsr_pkg::IF_SEL_RESET;
        else if (ifSelLoad)
            ifSel_q <= ifSelData;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path; override bytes show the code actually driving the lamp
    function automatic logic [7:0] readByte(input logic [11:0] addr);
        case (addr)
            alsr_pkg::OFS_REQ_LO:  readByte = {2'b00, req_q};
            alsr_pkg::OFS_STAT_LO: readByte = {2'b00, idLoaded_q, errInd_q, state_q};
            alsr_pkg::OFS_CODE_LO: readByte = reasonCode_q[7:0];
            alsr_pkg::OFS_CODE_HI: readByte = reasonCode_q[15:8];
            alsr_pkg::OFS_RUN_OVR: readByte = {3'b000, runEn_q, runEff};
            alsr_pkg::OFS_ERR_OVR: readByte = {3'b000, errEn_q, errEff};
            alsr_pkg::OFS_IF_SEL:  readByte = ifSel_q;
            default:               readByte = 8'h00;
        endcase
    endfunction

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            netRdata  <= 8'h00;
            hostRdata <= 8'h00;
        end
        else
        begin
            netRdata  <= netReq.rd ? readByte(netReq.addr) : 8'h00;
            hostRdata <= hostReq.rd ? readByte(hostReq.addr) : 8'h00;
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            alReqEvent <= 1'b0;
            hostEvtClr <= 1'b0;
            netEvtClr  <= 1'b0;
        end
        else
        begin
            alReqEvent <= netAccept;
            hostEvtClr <= hostRelease;
            netEvtClr  <= netReq.rd && (netReq.addr == alsr_pkg::OFS_STAT_LO
                                     || netReq.addr == alsr_pkg::OFS_STAT_HI);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Lamp tick divider and pattern generators
    localparam int TICK_W = $clog2(TICK_CYCLES + 1);
    logic [TICK_W-1:0] tickCnt_q;
    logic              tick;

    assign tick = tickCnt_q == TICK_W'(TICK_CYCLES - 1);

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            tickCnt_q <= '0;
        else
            tickCnt_q <= tick ? '0 : tickCnt_q + 1'b1;
    end

    alsr_lamp_gen uRunLamp (.mclk(mclk), .rstn(rstn), .tick(tick), .code(runEff),
                            .lampOut(runLamp));
    alsr_lamp_gen uErrLamp (.mclk(mclk), .rstn(rstn), .tick(tick), .code(errEff),
                            .lampOut(errLamp));

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    sequence netWriteWhileHeld;
        lock_q == alsr_pkg::LOCK_HELD && !emulationOn && !hostRelease && netReqHit;
    endsequence

    // A network write taken in the same cycle may grab the mailbox again
    sequence hostReleaseSeen;
        hostRelease && !netAccept ##1 hostEvtClr;
    endsequence

    AST_LOCK_BLOCKS: assert property (netWriteWhileHeld |=> $stable(req_q) && !alReqEvent)
        else $error("request changed while mailbox held");
    AST_RESET_OPEN: assert property ($rose(rstn) |-> lock_q == alsr_pkg::LOCK_OPEN)
        else $error("mailbox not open after reset");
    AST_RELEASE_OPENS: assert property (hostReleaseSeen |-> lock_q == alsr_pkg::LOCK_OPEN)
        else $error("host acknowledge did not release mailbox");
    AST_EMU_COPY: assert property (
        emulationOn && netReqHit && netReq.addr == alsr_pkg::OFS_REQ_LO
        |=> state_q == $past(netReq.wdata[3:0]) && alReqEvent)
        else $error("emulation did not copy request to actual state");
    AST_READ_ACK: assert property (!writeAckOn && hostReq.rd && hostReqHit |=> hostEvtClr)
        else $error("host read did not clear event");
    AST_WRITE_ACK: assert property (
        writeAckOn && hostReq.wr && hostReqHit
        |=> hostEvtClr && (req_q == $past(req_q) || $past(netAccept)))
        else $error("host write acknowledge missing");
    AST_NET_READ_CLR: assert property (
        netReq.rd && netReq.addr == alsr_pkg::OFS_STAT_LO
        |=> netEvtClr)
        else $error("network read of actual state did not clear event");
    AST_RUN_OVR_DROP: assert property (stateChange |=> !runEn_q)
        else $error("run override kept across state change");
    AST_ERR_OVR_DROP: assert property (errorEvent && !errInd_q |=> !errEn_q && errInd_q)
        else $error("fault override kept across new error");
    AST_RESERVED_ZERO: assert property (
        netReq.rd && netReq.addr == alsr_pkg::OFS_REQ_HI
        |=> netRdata == 8'h00)
        else $error("reserved request byte not zero");

endmodule

// [tb/alsr_cfg_model.sv]
// Purpose: Configuration memory stand-in that loads the interface select byte
// Assumes: Load happens once, a few cycles after reset is released
// Notes:   Data bus shows a changing pattern outside the load pulse
`timescale 1ns/100ps
module alsr_cfg_model
#(
    parameter logic [7:0] IF_CODE = 8'h05
)
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        resetn,
    // Load port
    output logic             ifSelLoad,
    output logic [7:0]       ifSelData
);
    int cnt;

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            cnt       <= 0;
            ifSelLoad <= 1'b0;
            ifSelData <= 8'h00;
        end
        else
        begin
            cnt       <= (cnt < 9) ? cnt + 1 : cnt;
            ifSelLoad <= (cnt == 4);
            // Stale data would hide a load that samples the wrong cycle
            ifSelData <= (cnt == 4) ? IF_CODE : ~ifSelData;
        end
    end
endmodule

// [tb/app_layer_state_regs_tb.sv]
// Purpose: Self-checking bench for the state register group
// Assumes: Byte accesses answer one cycle after they are taken
// Notes:   Lamp tick shortened to 4 cycles
`timescale 1ns/100ps
module app_layer_state_regs_tb;
    logic                mclk = 1'b0;
    logic                resetn;
    alsr_pkg::alsr_bus_s netReq;
    alsr_pkg::alsr_bus_s hostReq;
    logic [7:0]          netRdata;
    logic [7:0]          hostRdata;
    logic [7:0]          ifSelData;
    logic                emulationOn;
    logic                writeAckOn;
    logic                ifSelLoad;
    logic                errorEvent;
    logic                alReqEvent;
    logic                hostEvtClr;
    logic                netEvtClr;
    logic                runLamp;
    logic                errLamp;
    int                  err_count = 0;
    int                  samples_checked = 0;

    always #2.5 mclk = ~mclk;

    alsr_regs #(.TICK_CYCLES(4)) dut (.mclk(mclk), .resetn(resetn), .netReq(netReq),
        .netRdata(netRdata), .hostReq(hostReq), .hostRdata(hostRdata),
        .emulationOn(emulationOn), .writeAckOn(writeAckOn), .ifSelLoad(ifSelLoad),
        .ifSelData(ifSelData), .errorEvent(errorEvent), .alReqEvent(alReqEvent),
        .hostEvtClr(hostEvtClr), .netEvtClr(netEvtClr), .runLamp(runLamp),
        .errLamp(errLamp));

    alsr_cfg_model cfg (.mclk(mclk), .resetn(resetn), .ifSelLoad(ifSelLoad),
        .ifSelData(ifSelData));

    ////////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        if (err_count == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        samples_checked++;
        if (s !== e)
        begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask

    // Returns just after the edge where read data and side pulses stand
    task automatic acc(input bit net, input bit wr, input logic [11:0] a, input logic [7:0] d);
        alsr_pkg::alsr_bus_s r;
        r = '{wr, ~wr, a, d};
        @(posedge mclk);
        if (net)
            netReq <= r;
        else
            hostReq <= r;
        @(posedge mclk);
        netReq  <= '0;
        hostReq <= '0;
        #1;
    endtask

    task automatic rd(input bit net, input logic [11:0] a, input logic [7:0] e);
        acc(net, 1'b0, a, 8'h00);
        chk(net ? netRdata : hostRdata, e);
    endtask

    task automatic pulseErr;
        @(posedge mclk);
        errorEvent <= 1'b1;
        @(posedge mclk);
        errorEvent <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge mclk);
        err_count++;
        end_sim();
    end

    initial
    begin
        netReq = '0;
        hostReq = '0;
        emulationOn = 1'b0;
        writeAckOn = 1'b0;
        errorEvent = 1'b0;
        resetn = 1'b0;
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        repeat (3) @(posedge mclk);
        rd(1, 12'h130, 8'h01);
        rd(1, 12'h120, 8'h00);
        acc(1, 1, 12'h120, 8'h02);
        chk({7'h0, alReqEvent}, 8'h01);
        acc(1, 1, 12'h120, 8'h04);
        chk({7'h0, alReqEvent}, 8'h00);
        rd(1, 12'h120, 8'h02);
        rd(1, 12'h121, 8'h00);
        rd(0, 12'h121, 8'h00);
        chk({7'h0, hostEvtClr}, 8'h01);
        acc(1, 1, 12'h120, 8'h04);
        chk({7'h0, alReqEvent}, 8'h01);
        acc(0, 1, 12'h120, 8'h08);
        chk({7'h0, hostEvtClr}, 8'h00);
        rd(1, 12'h120, 8'h04);
        @(posedge mclk);
        writeAckOn <= 1'b1;
        acc(0, 1, 12'h120, 8'h08);
        chk({7'h0, hostEvtClr}, 8'h01);
        rd(0, 12'h120, 8'h04);
        rd(0, 12'h140, 8'h05);
        acc(1, 1, 12'h140, 8'h80);
        rd(1, 12'h140, 8'h05);
        acc(0, 1, 12'h130, 8'h12);
        acc(1, 1, 12'h130, 8'h08);
        rd(1, 12'h130, 8'h12);
        chk({7'h0, netEvtClr}, 8'h01);
        rd(1, 12'h131, 8'h00);
        acc(1, 1, 12'h120, 8'h14);
        rd(0, 12'h130, 8'h02);
        @(posedge mclk);
        emulationOn <= 1'b1;
        acc(1, 1, 12'h120, 8'h28);
        acc(1, 1, 12'h120, 8'h28);
        chk({7'h0, alReqEvent}, 8'h01);
        acc(0, 1, 12'h130, 8'h01);
        rd(0, 12'h130, 8'h28);
        acc(0, 1, 12'h134, 8'hA5);
        acc(0, 1, 12'h135, 8'h5A);
        acc(1, 1, 12'h134, 8'h00);
        rd(1, 12'h134, 8'hA5);
        rd(0, 12'h135, 8'h5A);
        acc(1, 1, 12'h138, 8'h1F);
        rd(0, 12'h138, 8'h1F);
        chk({7'h0, runLamp}, 8'h01);
        acc(1, 1, 12'h120, 8'h04);
        rd(1, 12'h138, 8'h01);
        acc(0, 1, 12'h139, 8'h10);
        rd(1, 12'h139, 8'h10);
        chk({7'h0, errLamp}, 8'h00);
        pulseErr();
        pulseErr();
        rd(0, 12'h139, 8'h0D);
        rd(0, 12'h130, 8'h14);
        // Blink restarts lit on the new code, then goes dark after four ticks
        chk({7'h0, errLamp}, 8'h01);
        repeat (20) @(posedge mclk);
        #1;
        chk({7'h0, errLamp}, 8'h00);
        end_sim();
    end
endmodule
